/* pkg/card_uart_irq_cfg.svh */
`ifndef CARD_UART_IRQ_CFG_SVH
`define CARD_UART_IRQ_CFG_SVH

// Special function address shared by both banks.
`define IDENT_ADDR 8'hae

// Bit positions of the flags and enables.
`define BIT_TBE  7
`define BIT_RSVD 6
`define BIT_COV  5
`define BIT_VERR 4
`define BIT_WTO  3
`define BIT_SENT 2
`define BIT_RCVD 1
`define BIT_PAR  0

// Reset values and the mask of defined bits.
`define IDENT_RST    8'h00
`define ENABLE_RST   8'h00
`define DEFINED_MASK 8'hbf

`endif

/* pkg/card_uart_irq_pkg.sv */
package card_uart_irq_pkg;

    typedef logic [7:0] byte_t;

    // Highest pending enabled source, first is highest.
    typedef enum logic [2:0] {
        SRC_TBE,
        SRC_COV,
        SRC_VERR,
        SRC_WTO,
        SRC_SENT,
        SRC_RCVD,
        SRC_PAR,
        SRC_NONE
    } src_e;

    // Whole state of the flag block.
    typedef struct packed {
        byte_t      flags;
        byte_t      en;
        byte_t      rdata;
        logic [2:0] cov_sync;
        logic [2:0] verr_sync;
        logic       cov_lvl;
        logic       verr_lvl;
        logic       irq;
        src_e       src;
    } state_s;

endpackage

/* verilog/card_uart_irq_flags.sv */
// How it works
// RULE_01: Set bit 7 on transmit buffer handover.
// RULE_02: Set bit 5 while current exceeds limit.
// RULE_03: Set bit 4 while voltage out of range.
// RULE_04: Set bit 3 on waiting counter expiry.
// RULE_05: Set bit 2 when character is sent.
// RULE_06: Set bit 1 when character is received.
// RULE_07: Bit 0 sets with 2/1 on parity error.
// RULE_08: A flag requests only when enabled.
// RULE_09: Reading identification register clears all flags; a flag whose event is on the read edge stays set.
// RULE_10: Same-edge events served in fixed priority.
// RULE_11: Software keeps a copy after reading.
// RULE_12: Reset reads zero, bit 6 reserved.
// RULE_13: Bank bit picks flags or enables.
// RULE_14: Request is OR of enabled flags.
`timescale 1ns/1ps

`include "card_uart_irq_cfg.svh"

module card_uart_irq_flags #(
    parameter int ADDR_W = 8
) (
    // Clock, reset and clock enable.
    input  wire logic                    clk_sys,
    input  wire logic                    nrst,
    input  wire logic                    ce,

    // Special function register port.
    input  wire logic [ADDR_W-1:0]       sfr_addr,
    input  wire logic                    sfr_rd,
    input  wire logic                    sfr_wr,
    input  wire card_uart_irq_pkg::byte_t sfr_wdata,
    output card_uart_irq_pkg::byte_t      sfr_rdata,
    input  wire logic                    reg_bank_select,

    // Events from the card UART and timers.
    input  wire logic                    ev_tx_buf_empty,
    input  wire logic                    ev_wait_timeout,
    input  wire logic                    ev_char_sent,
    input  wire logic                    ev_char_received,
    input  wire logic                    ev_parity_err,

    // Levels from the analog card supply.
    input  wire logic                    cur_over_async,
    input  wire logic                    volt_bad_async,

    // Interrupt request and source.
    output logic                         irq_out,
    output card_uart_irq_pkg::src_e      irq_src
);
    import card_uart_irq_pkg::*;

    // ----------------------------------
    // Elaboration checks
    // ----------------------------------

    // The address constant is eight bits wide.
    if (ADDR_W != 8) begin : g_bad_width
        $error("ADDR_W must be 8");
    end

    // ----------------------------------
    // Reset release
    // ----------------------------------

    logic [1:0] rst_sync_ff;
    logic       rst_n;

    // Release goes through two flops so it is clean.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync_ff <= 2'h0;
        end else if (ce) begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_ff[1];

    // ----------------------------------
    // Decode and events
    // ----------------------------------

    state_s cur_ff;
    state_s nxt_ff;
    logic   addr_hit;
    logic   ident_rd;
    logic   en_rd;
    logic   en_wr;
    byte_t  ev;
    byte_t  pend;

    // Bank select splits the one address in two.
    assign addr_hit = (sfr_addr == `IDENT_ADDR);
    assign ident_rd = sfr_rd & addr_hit & ~reg_bank_select; // [RULE_13]
    assign en_rd    = sfr_rd & addr_hit & reg_bank_select;  // [RULE_13]
    assign en_wr    = sfr_wr & addr_hit & reg_bank_select;  // [RULE_13]

    // Event vector laid out as the register.
    always_comb begin
        ev                = 8'h00;
        ev[`BIT_TBE]      = ev_tx_buf_empty;       // [RULE_01]
        ev[`BIT_COV]      = cur_ff.cov_lvl;        // [RULE_02]
        ev[`BIT_VERR]     = cur_ff.verr_lvl;       // [RULE_03]
        ev[`BIT_WTO]      = ev_wait_timeout;       // [RULE_04]
        ev[`BIT_SENT]     = ev_char_sent;          // [RULE_05]
        ev[`BIT_RCVD]     = ev_char_received;      // [RULE_06]
        // Parity flag only rides along a character end.
        ev[`BIT_PAR]      = ev_parity_err
                          & (ev_char_sent | ev_char_received); // [RULE_07]
    end

    // Flags that may request at all.
    assign pend = cur_ff.flags & cur_ff.en; // [RULE_08]

    // ----------------------------------
    // Priority
    // ----------------------------------

    // First set bit wins, from the top down.
    function automatic src_e prio(input byte_t p);
        src_e s;
        s = SRC_NONE;
        if (p[`BIT_TBE]) begin
            s = SRC_TBE;
        end else if (p[`BIT_COV]) begin
            s = SRC_COV;
        end else if (p[`BIT_VERR]) begin
            s = SRC_VERR;
        end else if (p[`BIT_WTO]) begin
            s = SRC_WTO;
        end else if (p[`BIT_SENT]) begin
            s = SRC_SENT;
        end else if (p[`BIT_RCVD]) begin
            s = SRC_RCVD;
        end else if (p[`BIT_PAR]) begin
            s = SRC_PAR;
        end
        return s;
    endfunction

    // ----------------------------------
    // Next state
    // ----------------------------------

    // The analog levels are asynchronous, so a change
    // counts only once the second and third stage agree.
    always_comb begin
        nxt_ff           = cur_ff;
        nxt_ff.cov_sync  = {cur_ff.cov_sync[1:0], cur_over_async};
        nxt_ff.verr_sync = {cur_ff.verr_sync[1:0], volt_bad_async};
        if (cur_ff.cov_sync[2] == cur_ff.cov_sync[1]) begin
            nxt_ff.cov_lvl = cur_ff.cov_sync[2];
        end
        if (cur_ff.verr_sync[2] == cur_ff.verr_sync[1]) begin
            nxt_ff.verr_lvl = cur_ff.verr_sync[2];
        end

        // Read clears, but an event on the same edge
        // wins so that nothing is lost.
        if (ident_rd) begin
            nxt_ff.flags = ev;                     // [RULE_09]
        end else begin
            nxt_ff.flags = cur_ff.flags | ev;
        end
        nxt_ff.flags[`BIT_RSVD] = 1'b0;            // [RULE_12]

        // Read data is held until the next read.
        if (ident_rd) begin
            nxt_ff.rdata = cur_ff.flags & `DEFINED_MASK; // [RULE_11]
        end else if (en_rd) begin
            nxt_ff.rdata = cur_ff.en;
        end

        // Reserved enable bit is never stored.
        if (en_wr) begin
            nxt_ff.en = sfr_wdata & `DEFINED_MASK;
        end

        nxt_ff.irq = |pend;                        // [RULE_14]
        nxt_ff.src = prio(pend);                   // [RULE_10]
    end

    // ----------------------------------
    // State register
    // ----------------------------------

    // Clock enable low freezes everything.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '{flags: `IDENT_RST, en: `ENABLE_RST,
                        rdata: 8'h00, cov_sync: 3'h0,
                        verr_sync: 3'h0, cov_lvl: 1'b0,
                        verr_lvl: 1'b0, irq: 1'b0,
                        src: SRC_NONE};    // [RULE_12]
        end else if (ce) begin
            cur_ff <= nxt_ff;
        end
    end

    // Outputs straight from flops.
    assign sfr_rdata = cur_ff.rdata;
    assign irq_out   = cur_ff.irq;
    assign irq_src   = cur_ff.src;

    // ----------------------------------
    // Checks
    // ----------------------------------

    property p_tbe_set;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && ev_tx_buf_empty |=> cur_ff.flags[`BIT_TBE];
    endproperty
    a_tbe_set: // [RULE_01]
        assert property (p_tbe_set) else $error("tbe flag not set");

    property p_cov_set;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && cur_ff.cov_lvl |=> cur_ff.flags[`BIT_COV];
    endproperty
    a_cov_set: // [RULE_02]
        assert property (p_cov_set) else $error("cov flag not set");

    property p_verr_set;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && cur_ff.verr_sync[2] && cur_ff.verr_sync[1]
        ##1 ce |=> cur_ff.flags[`BIT_VERR];
    endproperty
    a_verr_set: // [RULE_03]
        assert property (p_verr_set) else $error("verr flag late");

    property p_wto_set;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && ev_wait_timeout |=> cur_ff.flags[`BIT_WTO];
    endproperty
    a_wto_set: // [RULE_04]
        assert property (p_wto_set) else $error("wto flag not set");

    property p_sent_set;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && ev_char_sent |=> cur_ff.flags[`BIT_SENT];
    endproperty
    a_sent_set: // [RULE_05]
        assert property (p_sent_set) else $error("sent flag not set");

    property p_rcvd_set;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && ev_char_received |=> cur_ff.flags[`BIT_RCVD];
    endproperty
    a_rcvd_set: // [RULE_06]
        assert property (p_rcvd_set) else $error("rcvd flag not set");

    property p_par_alone;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && ev_parity_err && !ev_char_sent && !ev_char_received
        && (ident_rd || !cur_ff.flags[`BIT_PAR])
        |=> !cur_ff.flags[`BIT_PAR];
    endproperty
    a_par_alone: // [RULE_07]
        assert property (p_par_alone) else $error("parity set alone");

    property p_irq_or;
        @(posedge clk_sys) disable iff (!rst_n)
        ce |=> irq_out == |($past(cur_ff.flags) & $past(cur_ff.en));
    endproperty
    a_irq_or: // [RULE_14]
        assert property (p_irq_or) else $error("irq not OR of flags");

    property p_masked;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && pend == 8'h00 |=> !irq_out && irq_src == SRC_NONE;
    endproperty
    a_masked: // [RULE_08]
        assert property (p_masked) else $error("masked flag requests");

    property p_rd_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && ident_rd && ev == 8'h00
        |=> cur_ff.flags == 8'h00
            && sfr_rdata == ($past(cur_ff.flags) & `DEFINED_MASK);
    endproperty
    a_rd_clear: // [RULE_09]
        assert property (p_rd_clear) else $error("read did not clear");

    property p_prio_top;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && pend[`BIT_TBE] |=> irq_src == SRC_TBE;
    endproperty
    a_prio_top: // [RULE_10]
        assert property (p_prio_top) else $error("priority wrong");

    property p_prio_low;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && pend == 8'h01 |=> irq_src == SRC_PAR;
    endproperty
    a_prio_low: // [RULE_10]
        assert property (p_prio_low) else $error("parity prio wrong");

    property p_rsvd;
        @(posedge clk_sys) disable iff (!rst_n)
        !cur_ff.flags[`BIT_RSVD] && !cur_ff.en[`BIT_RSVD];
    endproperty
    a_rsvd: // [RULE_12]
        assert property (p_rsvd) else $error("reserved bit set");

    property p_bank_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && en_wr |=> cur_ff.en == ($past(sfr_wdata) & `DEFINED_MASK);
    endproperty
    a_bank_wr: // [RULE_13]
        assert property (p_bank_wr) else $error("enable write lost");

    property p_bank0_ro;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && sfr_wr && !reg_bank_select |=> $stable(cur_ff.en);
    endproperty
    a_bank0_ro: // [RULE_13]
        assert property (p_bank0_ro) else $error("bank 0 written");

    // Main scenarios.
    c_read_pending: cover property (@(posedge clk_sys)
        disable iff (!rst_n) ident_rd && cur_ff.flags != 8'h00);
    c_set_on_clear: cover property (@(posedge clk_sys)
        disable iff (!rst_n) ident_rd && ev != 8'h00);
    c_irq_rise: cover property (@(posedge clk_sys)
        disable iff (!rst_n) $rose(irq_out));
    c_two_events: cover property (@(posedge clk_sys)
        disable iff (!rst_n) ev_tx_buf_empty && ev_char_received);

endmodule // card_uart_irq_flags

/* test/sfr_host_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Core-side model of the special function register port
// ----------------------------------------
module sfr_host_model (
    // Clock.
    input  wire logic                     clk_sys,

    // Register port.
    output logic [7:0]                    sfr_addr,
    output logic                          sfr_rd,
    output logic                          sfr_wr,
    output card_uart_irq_pkg::byte_t      sfr_wdata,
    output logic                          reg_bank_select,
    input  wire card_uart_irq_pkg::byte_t sfr_rdata
);
    import card_uart_irq_pkg::*;

    byte_t saved_ident;

    // Idle values at time zero, before any access.
    initial begin
        sfr_addr = 8'h00;
        sfr_rd = 1'b0;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        reg_bank_select = 1'b0;
        saved_ident = 8'h00;
    end

    // One access, entered just after an edge; the strobe is held to the taking edge.
    // An extra edge passes before return so a strobe is never dropped and raised together.
    task automatic access(input logic wr, input logic bank, input logic [7:0] addr,
                          input byte_t wd, output byte_t rd);
        sfr_addr = addr;
        reg_bank_select = bank;
        sfr_wdata = wd;
        sfr_rd = !wr;
        sfr_wr = wr;
        @(posedge clk_sys);
        #1;
        sfr_rd = 1'b0;
        sfr_wr = 1'b0;
        sfr_wdata = ~wd;
        sfr_addr = ~addr;
        rd = sfr_rdata;
        // The read cleared the flags, so the value is kept at once.
        if (!wr && !bank && addr == 8'hae) begin
            saved_ident = rd;
        end
        @(posedge clk_sys);
        #1;
    endtask
endmodule // sfr_host_model

/* test/card_uart_irq_flags_test.sv */
`timescale 1ns/1ps

`include "card_uart_irq_cfg.svh"

module card_uart_irq_flags_test;
    import card_uart_irq_pkg::*;

    logic [7:0] sfr_addr;
    logic       clk_sys, nrst, ce, sfr_rd, sfr_wr, reg_bank_select, irq_out;
    byte_t      sfr_wdata, sfr_rdata, rd;
    src_e       irq_src;
    logic [4:0] ev;
    logic       cur_over_async, volt_bad_async;
    int         fails, total_checks;

    sfr_host_model u_host (.clk_sys(clk_sys), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .reg_bank_select(reg_bank_select),
        .sfr_rdata(sfr_rdata));

    card_uart_irq_flags u_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .sfr_addr(sfr_addr),
        .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .reg_bank_select(reg_bank_select), .ev_tx_buf_empty(ev[4]), .ev_wait_timeout(ev[3]),
        .ev_char_sent(ev[2]), .ev_char_received(ev[1]), .ev_parity_err(ev[0]),
        .cur_over_async(cur_over_async), .volt_bad_async(volt_bad_async),
        .irq_out(irq_out), .irq_src(irq_src));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One-cycle event pulse; flags land at the edge, the request one edge later.
    task automatic pulse(input logic [4:0] m);
        ev = m;
        @(posedge clk_sys);
        #1;
        ev = 5'h00;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic wr_en(input byte_t v);
        u_host.access(1'b1, 1'b1, `IDENT_ADDR, v, rd);
    endtask

    task automatic rd_ident(input byte_t exp, input string what);
        u_host.access(1'b0, 1'b0, `IDENT_ADDR, 8'h00, rd);
        check(rd & `DEFINED_MASK, exp, what);
        check(u_host.saved_ident & `DEFINED_MASK, exp, what);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        check({7'h00, irq_out}, 8'h00, "irq after reset");
        check({5'h00, irq_src}, {5'h00, SRC_NONE}, "src after reset");
        rd_ident(8'h00, "ident after reset");
    endtask

    // Writes into bank 0 and reads elsewhere must leave the enables and rdata alone.
    task automatic t_bank();
        wr_en(8'hff);
        u_host.access(1'b1, 1'b0, `IDENT_ADDR, 8'h00, rd);
        u_host.access(1'b0, 1'b1, `IDENT_ADDR, 8'h00, rd);
        check(rd, 8'hbf, "enable readback");
        u_host.access(1'b0, 1'b0, 8'had, 8'h00, rd);
        check(rd, 8'hbf, "unmapped read");
    endtask

    // Each pulse source alone; parity without a character is refused.
    task automatic t_single();
        logic [4:0] m [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h03, 5'h01};
        logic [7:0] x [6] = '{8'h80, 8'h08, 8'h04, 8'h02, 8'h03, 8'h00};
        src_e       s [6] = '{SRC_TBE, SRC_WTO, SRC_SENT, SRC_RCVD, SRC_RCVD, SRC_NONE};
        for (int i = 0; i < 6; i++) begin
            pulse(m[i]);
            check({7'h00, irq_out}, {7'h00, x[i] != 8'h00}, "irq set");
            check({5'h00, irq_src}, {5'h00, s[i]}, "src single");
            rd_ident(x[i], "flag bits");
            check({7'h00, irq_out}, 8'h00, "irq after read");
            rd_ident(8'h00, "ident cleared");
        end
    endtask

    task automatic t_priority();
        pulse(5'h1f);
        check({5'h00, irq_src}, {5'h00, SRC_TBE}, "src all");
        rd_ident(8'h8f, "all flags");
        wr_en(8'h06);
        pulse(5'h16);
        check({5'h00, irq_src}, {5'h00, SRC_SENT}, "src masked");
        check({7'h00, irq_out}, 8'h01, "irq masked on");
        rd_ident(8'h86, "masked flags");
        wr_en(8'h00);
        pulse(5'h1f);
        check({7'h00, irq_out}, 8'h00, "irq all masked");
        rd_ident(8'h8f, "flags masked off");
        wr_en(8'hbf);
    endtask

    // Supply levels pass a synchroniser, so a few cycles are allowed before the flag.
    task automatic t_levels();
        for (int i = 0; i < 2; i++) begin
            {cur_over_async, volt_bad_async} = (i == 0) ? 2'b10 : 2'b01;
            repeat (6) @(posedge clk_sys);
            #1;
            check({5'h00, irq_src}, {5'h00, (i == 0) ? SRC_COV : SRC_VERR}, "src level");
            rd_ident((i == 0) ? 8'h20 : 8'h10, "level flag");
            rd_ident((i == 0) ? 8'h20 : 8'h10, "level held");
            {cur_over_async, volt_bad_async} = 2'b00;
            repeat (6) @(posedge clk_sys);
            #1;
            rd_ident((i == 0) ? 8'h20 : 8'h10, "level last");
            rd_ident(8'h00, "level gone");
        end
    endtask

    // Clock enable low freezes events, reads and the request; parity rides a sent character.
    task automatic t_freeze();
        wr_en(8'h01);
        pulse(5'h05);
        check({5'h00, irq_src}, {5'h00, SRC_PAR}, "src parity");
        ce = 1'b0;
        pulse(5'h10);
        u_host.access(1'b0, 1'b0, `IDENT_ADDR, 8'h00, rd);
        check({7'h00, irq_out}, 8'h01, "irq frozen");
        ce = 1'b1;
        rd_ident(8'h05, "flags frozen");
        wr_en(8'hbf);
    endtask

    // A reset in mid-run clears flags and enables alike.
    task automatic t_rerun();
        pulse(5'h08);
        nrst = 1'b0;
        @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        check({7'h00, irq_out}, 8'h00, "irq after rerun");
        rd_ident(8'h00, "ident after rerun");
        u_host.access(1'b0, 1'b1, `IDENT_ADDR, 8'h00, rd);
        check(rd, `ENABLE_RST, "enable after rerun");
    endtask

    // ----------------------------------------
    // Clock, reset, sequence and verdict
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #50000;
        fails++;
        conclude();
    end

    initial begin
        fails = 0;
        total_checks = 0;
        nrst = 1'b0;
        ce = 1'b1;
        ev = 5'h00;
        cur_over_async = 1'b0;
        volt_bad_async = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        t_reset();
        t_bank();
        t_single();
        t_priority();
        t_levels();
        t_freeze();
        t_rerun();
        conclude();
    end
endmodule // card_uart_irq_flags_test
